// [hw/cssb_fifo.v]
// Flip-flop FIFO holding converter results on their way to the serial port
`timescale 1ns/10ps
module cssb_fifo #(
  parameter WIDTH = 16,
  parameter DEPTH = 32,
  parameter AW    = 5
) (
  input  wire             ref_clk,
  input  wire             reset,
  input  wire [WIDTH-1:0] in_data,
  input  wire             in_valid,
  output wire             in_ready,
  output wire [WIDTH-1:0] out_data,
  output wire             out_valid,
  input  wire             out_ready
);

  // ----------------------------------------------------------------------------
  // Storage and pointers
  // ----------------------------------------------------------------------------
  reg [WIDTH-1:0] mem_q [0:DEPTH-1];
  reg [AW-1:0]    wr_ptr_q;
  reg [AW-1:0]    rd_ptr_q;
  reg [AW:0]      count_q;

  wire push = in_valid & in_ready;
  wire pop  = out_valid & out_ready;

  assign in_ready  = (count_q != DEPTH[AW:0]);
  assign out_valid = (count_q != {(AW+1){1'b0}});
  assign out_data  = mem_q[rd_ptr_q];

  always @(posedge ref_clk) begin
    if (push) begin
      mem_q[wr_ptr_q] <= in_data;
    end
  end

  // Pointers wrap naturally since depth is a power of two
  always @(posedge ref_clk) begin
    if (reset) begin
      wr_ptr_q <= {AW{1'b0}};
      rd_ptr_q <= {AW{1'b0}};
      count_q  <= {(AW+1){1'b0}};
    end else begin
      if (push) begin
        wr_ptr_q <= wr_ptr_q + 1'b1;
      end
      if (pop) begin
        rd_ptr_q <= rd_ptr_q + 1'b1;
      end
      if (push & ~pop) begin
        count_q <= count_q + 1'b1;
      end else if (pop & ~push) begin
        count_q <= count_q - 1'b1;
      end
    end
  end

endmodule

// [hw/cssb_regs.vh]
// Constants for the codec serial sideband block: register map, field positions, formats
`ifndef CSSB_REGS_VH
`define CSSB_REGS_VH

// ----------------------------------------------------------------------------
// Register offsets (byte addresses on the plain register port)
// ----------------------------------------------------------------------------
`define CSSB_ADDR_CTRL        8'h00
`define CSSB_ADDR_STAT        8'h04
`define CSSB_ADDR_RXWORD      8'h08

// ----------------------------------------------------------------------------
// Control register fields
// ----------------------------------------------------------------------------
`define CSSB_CTRL_SEC_REQ     0
`define CSSB_CTRL_BIT_TEN     10
`define CSSB_CTRL_BIT_ELEVEN  11
`define CSSB_CTRL_RESET       32'h0000_0000

// ----------------------------------------------------------------------------
// Status register fields
// ----------------------------------------------------------------------------
`define CSSB_STAT_STATE_LSB   0
`define CSSB_STAT_DUAL        4
`define CSSB_STAT_BYTE_FMT    5
`define CSSB_STAT_SEC_FRAME   6
`define CSSB_STAT_FIFO_READY  8
`define CSSB_STAT_FIFO_VALID  9

// ----------------------------------------------------------------------------
// Serial formats and buffering
// ----------------------------------------------------------------------------
`define CSSB_WORD_BITS        16
`define CSSB_WORD_LAST        4'hf
`define CSSB_BYTE_LAST        4'h7
`define CSSB_FIFO_DEPTH       32
`define CSSB_FIFO_AW          5

`endif

// [hw/cssb_top.v]
// Codec serial port sideband: frame syncs, end strobes, secondary sync, general outputs
`timescale 1ns/10ps
`include "cssb_regs.vh"
module cssb_top (
  input  wire        ref_clk,
  input  wire        reset,
  input  wire [7:0]  reg_addr,
  input  wire [31:0] reg_wdata,
  input  wire        reg_wr,
  input  wire        reg_rd,
  output wire [31:0] reg_rdata,
  input  wire [15:0] adc_data,
  input  wire        adc_valid,
  output wire        adc_ready,
  output wire [15:0] dac_data,
  output wire        dac_valid,
  output wire        dac_secondary,
  input  wire        shift_clk,
  input  wire        mode_control_pin,
  input  wire        word_byte_select,
  input  wire        secondary_data_in,
  input  wire        serial_data_in,
  output wire        serial_data_out,
  output wire        transmit_frame_sync,
  output wire        receive_frame_sync,
  output wire        secondary_frame_sync,
  output wire        transmit_end_strobe,
  output wire        receive_end_strobe,
  output wire        general_output_a,
  output wire        general_output_b
);

  // ----------------------------------------------------------------------------
  // States and helpers
  // ----------------------------------------------------------------------------
  localparam [1:0] ST_IDLE  = 2'd0;
  localparam [1:0] ST_SHIFT = 2'd1;
  localparam [1:0] ST_GAP   = 2'd2;
  localparam [1:0] ST_END   = 2'd3;
  localparam [31:0] CTRL_RST = `CSSB_CTRL_RESET;

  // Index of the last bit of the current word or byte
  function [3:0] last_index;
    input byte_fmt;
    begin
      last_index = byte_fmt ? `CSSB_BYTE_LAST : `CSSB_WORD_LAST;
    end
  endfunction

  // True when the whole word (or the second byte) is complete
  function frame_done;
    input byte_fmt;
    input second_half;
    begin
      frame_done = ~byte_fmt | second_half;
    end
  endfunction

  // ----------------------------------------------------------------------------
  // Pin synchronisers
  // ----------------------------------------------------------------------------
  // Bit order: 0 shift clock, 1 control pin, 2 format select, 3 secondary data, 4 data in
  reg  [4:0] sync1_q;
  reg  [4:0] sync2_q;
  reg        sclk_prev_q;

  always @(posedge ref_clk) begin
    if (reset) begin
      sync1_q     <= 5'h00;
      sync2_q     <= 5'h00;
      sclk_prev_q <= 1'b0;
    end else begin
      sync1_q     <= {serial_data_in, secondary_data_in, word_byte_select, mode_control_pin, shift_clk};
      sync2_q     <= sync1_q;
      sclk_prev_q <= sync2_q[0];
    end
  end

  wire sclk_rise = sync2_q[0] & ~sclk_prev_q;
  wire sclk_fall = ~sync2_q[0] & sclk_prev_q;
  // Control pin high selects word-or-byte mode, low selects dual-word mode
  wire dual_mode = ~sync2_q[1];
  wire byte_sel  = ~dual_mode & ~sync2_q[2];
  wire sec_din   = sync2_q[3];
  wire ser_din   = sync2_q[4];

  // ----------------------------------------------------------------------------
  // Control register
  // ----------------------------------------------------------------------------
  reg  ctrl_ten_q;
  reg  ctrl_eleven_q;
  reg  sec_req_q;
  wire ctrl_wr = reg_wr & (reg_addr == `CSSB_ADDR_CTRL);
  wire sec_start;

  always @(posedge ref_clk) begin
    if (reset) begin
      ctrl_ten_q    <= CTRL_RST[`CSSB_CTRL_BIT_TEN];
      ctrl_eleven_q <= CTRL_RST[`CSSB_CTRL_BIT_ELEVEN];
      sec_req_q     <= 1'b0;
    end else begin
      if (ctrl_wr) begin
        ctrl_ten_q    <= reg_wdata[`CSSB_CTRL_BIT_TEN];
        ctrl_eleven_q <= reg_wdata[`CSSB_CTRL_BIT_ELEVEN];
      end
      // A fresh request in the cycle the frame starts is kept
      sec_req_q <= (ctrl_wr & reg_wdata[`CSSB_CTRL_SEC_REQ]) | (sec_req_q & ~sec_start);
    end
  end

  // Combinational from the register so the pin moves with the write itself
  assign general_output_a = dual_mode & ctrl_ten_q;
  assign general_output_b = dual_mode & ctrl_eleven_q;

  // ----------------------------------------------------------------------------
  // Result buffer
  // ----------------------------------------------------------------------------
  wire [15:0] fifo_data;
  wire        fifo_valid;
  wire        fifo_pop;

  cssb_fifo #(
    .WIDTH (`CSSB_WORD_BITS),
    .DEPTH (`CSSB_FIFO_DEPTH),
    .AW    (`CSSB_FIFO_AW)
  ) u_fifo (
    .ref_clk   (ref_clk),
    .reset     (reset),
    .in_data   (adc_data),
    .in_valid  (adc_valid),
    .in_ready  (adc_ready),
    .out_data  (fifo_data),
    .out_valid (fifo_valid),
    .out_ready (fifo_pop)
  );

  // ----------------------------------------------------------------------------
  // Frame engine
  // ----------------------------------------------------------------------------
  reg [1:0]  state_q;
  reg [3:0]  bit_cnt_q;
  reg        half_q;
  reg        last_q;
  reg        byte_q;
  reg        sec_q;
  reg        fs_q;
  reg        eod_q;
  reg        dout_q;
  reg [15:0] tx_sr_q;
  reg [15:0] rx_sr_q;
  reg [15:0] dac_data_q;
  reg        dac_valid_q;
  reg        dac_sec_q;

  // Secondary frames take priority so control traffic is never starved by data
  assign sec_start = sclk_rise & (state_q == ST_IDLE) & sec_req_q & dual_mode;
  assign fifo_pop  = sclk_rise & (state_q == ST_IDLE) & ~(sec_req_q & dual_mode) & fifo_valid;

  always @(posedge ref_clk) begin
    if (reset) begin
      state_q     <= ST_IDLE;
      bit_cnt_q   <= 4'h0;
      half_q      <= 1'b0;
      last_q      <= 1'b0;
      byte_q      <= 1'b0;
      sec_q       <= 1'b0;
      fs_q        <= 1'b1;
      eod_q       <= 1'b1;
      dout_q      <= 1'b0;
      tx_sr_q     <= 16'h0000;
      rx_sr_q     <= 16'h0000;
      dac_data_q  <= 16'h0000;
      dac_valid_q <= 1'b0;
      dac_sec_q   <= 1'b0;
    end else begin
      dac_valid_q <= 1'b0;
      if (sclk_rise) begin
        case (state_q)
          ST_IDLE: begin
            if (sec_start) begin
              sec_q     <= 1'b1;
              byte_q    <= 1'b0;
              fs_q      <= 1'b0;
              dout_q    <= sec_din;
              bit_cnt_q <= 4'h0;
              half_q    <= 1'b0;
              state_q   <= ST_SHIFT;
            end else if (fifo_valid) begin
              sec_q     <= 1'b0;
              byte_q    <= byte_sel;  // format frozen for the whole frame
              tx_sr_q   <= fifo_data;
              fs_q      <= 1'b0;
              dout_q    <= fifo_data[15];
              bit_cnt_q <= 4'h0;
              half_q    <= 1'b0;
              state_q   <= ST_SHIFT;
            end
          end
          ST_SHIFT: begin
            if (last_q) begin
              last_q <= 1'b0;
              fs_q   <= 1'b1;
              if (byte_q & ~half_q) begin
                eod_q   <= 1'b0;
                state_q <= ST_GAP;
              end else if (byte_q) begin
                eod_q   <= 1'b1;
                state_q <= ST_IDLE;
              end else if (~sec_q & ~dual_mode) begin
                eod_q   <= 1'b0;
                state_q <= ST_END;
              end else begin
                state_q <= ST_IDLE;
              end
            end else begin
              dout_q <= sec_q ? sec_din : tx_sr_q[15];
            end
          end
          ST_GAP: begin
            fs_q      <= 1'b0;
            half_q    <= 1'b1;
            bit_cnt_q <= 4'h0;
            dout_q    <= tx_sr_q[15];
            state_q   <= ST_SHIFT;
          end
          ST_END: begin
            eod_q   <= 1'b1;
            state_q <= ST_IDLE;
          end
          default: begin
            state_q <= ST_IDLE;
          end
        endcase
      end else if (sclk_fall & (state_q == ST_SHIFT) & ~last_q) begin
        rx_sr_q <= {rx_sr_q[14:0], ser_din};
        tx_sr_q <= {tx_sr_q[14:0], 1'b0};
        if (bit_cnt_q == last_index(byte_q)) begin
          last_q    <= 1'b1;
          bit_cnt_q <= 4'h0;
          if (frame_done(byte_q, half_q)) begin
            dac_data_q  <= {rx_sr_q[14:0], ser_din};
            dac_valid_q <= 1'b1;
            dac_sec_q   <= sec_q;
          end
        end else begin
          bit_cnt_q <= bit_cnt_q + 4'h1;
        end
      end
    end
  end

  // ----------------------------------------------------------------------------
  // Pin outputs
  // ----------------------------------------------------------------------------
  assign serial_data_out      = dout_q;
  assign transmit_frame_sync  = fs_q;
  assign receive_frame_sync   = fs_q;
  // Primary frames and word-or-byte mode keep it high
  assign secondary_frame_sync = (dual_mode & sec_q) ? fs_q : 1'b1;
  // Both directions run full duplex, so one strobe source serves both pins
  assign transmit_end_strobe  = dual_mode ? 1'b1 : eod_q;
  assign receive_end_strobe   = dual_mode ? 1'b1 : eod_q;
  assign dac_data             = dac_data_q;
  assign dac_valid            = dac_valid_q;
  assign dac_secondary        = dac_sec_q;

  // ----------------------------------------------------------------------------
  // Register read port
  // ----------------------------------------------------------------------------
  reg [31:0] rdata_q;
  reg [31:0] rdata_d;

  always @* begin
    rdata_d = 32'h0000_0000;
    case (reg_addr)
      `CSSB_ADDR_CTRL: begin
        rdata_d[`CSSB_CTRL_SEC_REQ]    = sec_req_q;
        rdata_d[`CSSB_CTRL_BIT_TEN]    = ctrl_ten_q;
        rdata_d[`CSSB_CTRL_BIT_ELEVEN] = ctrl_eleven_q;
      end
      `CSSB_ADDR_STAT: begin
        rdata_d[`CSSB_STAT_STATE_LSB+1:`CSSB_STAT_STATE_LSB] = state_q;
        rdata_d[`CSSB_STAT_DUAL]       = dual_mode;
        rdata_d[`CSSB_STAT_BYTE_FMT]   = byte_sel;
        rdata_d[`CSSB_STAT_SEC_FRAME]  = sec_q;
        rdata_d[`CSSB_STAT_FIFO_READY] = adc_ready;
        rdata_d[`CSSB_STAT_FIFO_VALID] = fifo_valid;
      end
      `CSSB_ADDR_RXWORD: begin
        rdata_d[15:0] = dac_data_q;
      end
      default: begin
        rdata_d = 32'h0000_0000;
      end
    endcase
  end

  // Read data stand only in the cycle after the strobe
  always @(posedge ref_clk) begin
    if (reset) begin
      rdata_q <= 32'h0000_0000;
    end else if (reg_rd) begin
      rdata_q <= rdata_d;
    end else begin
      rdata_q <= 32'h0000_0000;
    end
  end

  assign reg_rdata = rdata_q;

endmodule

// [tb/cssb_proc_model.sv]
// Processor serial port model: free shift clock, word shifters both ways
`timescale 1ns/10ps
module cssb_proc_model (
  output logic        shift_clk,
  input  logic        transmit_frame_sync,
  input  logic        receive_frame_sync,
  input  logic        serial_data_out,
  output logic        serial_data_in,
  input  logic [15:0] tx_word,
  output logic [15:0] rx_word,
  output logic [7:0]  rx_cnt
);
  logic [3:0]  tx_n = 4'h0;
  logic [3:0]  rx_n = 4'h0;
  logic [15:0] rx_sh = 16'h0;
  logic        took = 1'b0;
  initial shift_clk = 1'b0;
  initial rx_cnt = 8'h00;
  initial rx_word = 16'h0;
  always #24 shift_clk = ~shift_clk;
  // Off frame the line shows the inverse, so a stale bit never passes for data
  assign serial_data_in = tx_word[~tx_n] ^ transmit_frame_sync;
  always @(negedge shift_clk) begin
    took <= !transmit_frame_sync;
    if (!receive_frame_sync) begin
      rx_sh = {rx_sh[14:0], serial_data_out};
      rx_n = rx_n + 4'h1;
      if (rx_n == 4'h0) begin
        rx_word <= rx_sh;
        rx_cnt <= rx_cnt + 8'h01;
      end
    end
  end
  always @(posedge shift_clk) if (took) tx_n <= tx_n + 4'h1;
endmodule

// [tb/cssb_properties.sv]
// Checker of the sideband pins, bound into the block's top module
`timescale 1ns/10ps
module cssb_properties (
  input logic        ref_clk,
  input logic        reset,
  input logic [7:0]  reg_addr,
  input logic [31:0] reg_wdata,
  input logic        reg_wr,
  input logic        mode_control_pin,
  input logic        word_byte_select,
  input logic        transmit_frame_sync,
  input logic        receive_frame_sync,
  input logic        secondary_frame_sync,
  input logic        transmit_end_strobe,
  input logic        receive_end_strobe,
  input logic        general_output_a,
  input logic        general_output_b
);
  logic [2:0] age_q;
  logic [3:0] mhist_q;
  logic [7:0] lo_q;
  logic       dual_s;
  logic       wob_s;
  logic       byte_s;
  // Mode only counts once the pin has outlived the synchroniser
  always_ff @(posedge ref_clk) begin
    mhist_q <= {mhist_q[2:0], mode_control_pin};
    lo_q <= transmit_frame_sync ? 8'h00 : lo_q + {7'h0, lo_q != 8'hff};
    if (reset) age_q <= 3'h0;
    else if (age_q != 3'h7) age_q <= age_q + 3'h1;
  end
  assign dual_s = age_q == 3'h7 && mhist_q == 4'h0 && !mode_control_pin;
  assign wob_s  = age_q == 3'h7 && mhist_q == 4'hf && mode_control_pin;
  assign byte_s = wob_s && !word_byte_select;
  default clocking cb @(posedge ref_clk); endclocking
  default disable iff (reset);
  property p_go_a; reg_wr && reg_addr == 8'h00 && dual_s |=> general_output_a == $past(reg_wdata[10]); endproperty
  a_go_a: assert property (p_go_a) else $error("output a missed write");
  property p_go_b; reg_wr && reg_addr == 8'h00 && dual_s |=> general_output_b == $past(reg_wdata[11]); endproperty
  a_go_b: assert property (p_go_b) else $error("output b missed write");
  property p_rst_low; $fell(reset) |-> !general_output_a && !general_output_b; endproperty
  a_rst_low: assert property (p_rst_low) else $error("outputs not low after reset");
  property p_dual_only; wob_s |-> !general_output_a && !general_output_b && secondary_frame_sync; endproperty
  a_dual_only: assert property (p_dual_only) else $error("dual pins active in word mode");
  property p_eod_mode; dual_s |-> transmit_end_strobe && receive_end_strobe; endproperty
  a_eod_mode: assert property (p_eod_mode) else $error("end strobe in dual mode");
  property p_sec; !secondary_frame_sync |-> !transmit_frame_sync && dual_s; endproperty
  a_sec: assert property (p_sec) else $error("secondary sync off frame");
  property p_pair; transmit_end_strobe == receive_end_strobe && transmit_frame_sync == receive_frame_sync; endproperty
  a_pair: assert property (p_pair) else $error("strobes differ");
  property p_eod_fall; $fell(transmit_end_strobe) |-> $rose(transmit_frame_sync); endproperty
  a_eod_fall: assert property (p_eod_fall) else $error("strobe not at frame end");
  property p_eod_rise; $rose(transmit_end_strobe) && byte_s |-> $rose(transmit_frame_sync); endproperty
  a_eod_rise: assert property (p_eod_rise) else $error("byte strobe rose early");
  property p_eod_pulse; $fell(transmit_end_strobe) && wob_s && word_byte_select |->
    !transmit_end_strobe[*8] ##[2:3] transmit_end_strobe; endproperty
  a_eod_pulse: assert property (p_eod_pulse) else $error("word strobe width");
  property p_fs_len; $rose(transmit_frame_sync) && age_q == 3'h7 |->
    (byte_s ? lo_q inside {[75:78]} : lo_q inside {[152:155]}); endproperty
  a_fs_len: assert property (p_fs_len) else $error("frame sync low length");
endmodule
bind cssb_top cssb_properties i_cssb_properties (.ref_clk(ref_clk), .reset(reset), .reg_addr(reg_addr),
  .reg_wdata(reg_wdata), .reg_wr(reg_wr), .mode_control_pin(mode_control_pin), .word_byte_select(word_byte_select),
  .transmit_frame_sync(transmit_frame_sync), .receive_frame_sync(receive_frame_sync),
  .secondary_frame_sync(secondary_frame_sync), .transmit_end_strobe(transmit_end_strobe),
  .receive_end_strobe(receive_end_strobe), .general_output_a(general_output_a), .general_output_b(general_output_b));

// [tb/cssb_tb_top.sv]
// Bench for the codec serial sideband block
`timescale 1ns/10ps
`include "cssb_regs.vh"
module cssb_tb_top;
  logic        ref_clk = 1'b0, reset = 1'b1, reg_wr = 1'b0, reg_rd = 1'b0, adc_valid = 1'b0, clr = 1'b0;
  logic        mode_control_pin = 1'b0, word_byte_select = 1'b1, secondary_data_in = 1'b0;
  logic [7:0]  reg_addr = 8'h00, rx_cnt, lo_n = 8'h00, lo_last = 8'h00;
  logic [31:0] reg_wdata = 32'h0, reg_rdata;
  logic [15:0] adc_data = 16'h0, tx_word = 16'h0, dac_got = 16'h0, dac_data, rx_word;
  logic        adc_ready, dac_valid, dac_secondary, shift_clk, serial_data_in, serial_data_out, r;
  logic        transmit_frame_sync, receive_frame_sync, secondary_frame_sync, transmit_end_strobe;
  logic        receive_end_strobe, general_output_a, general_output_b;
  logic        dac_sec = 1'b0, sec_low = 1'b0, eod_low = 1'b0;
  int          fails = 0, samples_checked = 0, cyc = 0, n, k;
  cssb_top i_cssb_top (.ref_clk(ref_clk), .reset(reset), .reg_addr(reg_addr), .reg_wdata(reg_wdata),
    .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(reg_rdata), .adc_data(adc_data), .adc_valid(adc_valid),
    .adc_ready(adc_ready), .dac_data(dac_data), .dac_valid(dac_valid), .dac_secondary(dac_secondary),
    .shift_clk(shift_clk), .mode_control_pin(mode_control_pin), .word_byte_select(word_byte_select),
    .secondary_data_in(secondary_data_in), .serial_data_in(serial_data_in), .serial_data_out(serial_data_out),
    .transmit_frame_sync(transmit_frame_sync), .receive_frame_sync(receive_frame_sync),
    .secondary_frame_sync(secondary_frame_sync), .transmit_end_strobe(transmit_end_strobe),
    .receive_end_strobe(receive_end_strobe), .general_output_a(general_output_a),
    .general_output_b(general_output_b));
  cssb_proc_model i_cssb_proc_model (.shift_clk(shift_clk), .transmit_frame_sync(transmit_frame_sync),
    .receive_frame_sync(receive_frame_sync), .serial_data_out(serial_data_out), .serial_data_in(serial_data_in),
    .tx_word(tx_word), .rx_word(rx_word), .rx_cnt(rx_cnt));
  always #2.5 ref_clk = ~ref_clk;
  // Monitor: last strobe low width and sticky flags, cleared by clr
  always @(posedge ref_clk) begin
    cyc <= cyc + 1;
    if (cyc == 20000) begin
      fails = fails + 1;
      stop_test;
    end
    if (!transmit_end_strobe) lo_n <= lo_n + 8'h01;
    else if (lo_n != 8'h00) begin
      lo_last <= lo_n;
      lo_n <= 8'h00;
    end
    sec_low <= !clr && (sec_low || !secondary_frame_sync);
    eod_low <= !clr && (eod_low || !transmit_end_strobe);
    if (clr) dac_sec <= 1'b0;
    if (dac_valid) begin
      dac_got <= dac_data;
      dac_sec <= dac_secondary;
    end
  end
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    samples_checked++;
    if (got !== exp) begin
      fails++;
      $display("BAD t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask
  task automatic wr(input logic [7:0] a, input logic [31:0] v);
    @(posedge ref_clk);
    reg_wr <= 1'b1;
    reg_addr <= a;
    reg_wdata <= v;
    @(posedge ref_clk);
    reg_wr <= 1'b0;
  endtask
  task automatic rd(input logic [7:0] a, input logic [31:0] exp);
    @(posedge ref_clk);
    reg_rd <= 1'b1;
    reg_addr <= a;
    @(posedge ref_clk);
    reg_rd <= 1'b0;
    #1 chk(reg_rdata, exp);
  endtask
  task automatic pins(input logic m, input logic w);
    @(posedge ref_clk);
    mode_control_pin <= m;
    word_byte_select <= w;
    repeat (6) @(posedge ref_clk);
    clr <= 1'b1;
    @(posedge ref_clk);
    clr <= 1'b0;
  endtask
  task automatic wait_rx(input int c);
    for (int i = 0; i < 8000 && rx_cnt != c[7:0]; i++) @(posedge ref_clk);
    chk({24'h0, rx_cnt}, c);
    repeat (40) @(posedge ref_clk);
  endtask
  task automatic frame(input logic [15:0] a, input logic [15:0] x);
    n = rx_cnt;
    tx_word <= x;
    @(posedge ref_clk);
    adc_data <= a;
    adc_valid <= 1'b1;
    @(posedge ref_clk);
    adc_valid <= 1'b0;
    wait_rx(n + 1);
  endtask
  task automatic stop_test;
    $display("Comparisons %0d, mismatches %0d", samples_checked, fails);
    if (fails == 0 && samples_checked > 0) $display("No errors found");
    else $display("Errors were found");
    $finish;
  endtask
  initial begin
    repeat (8) @(posedge ref_clk);
    reset <= 1'b0;
    #1 chk({general_output_a, general_output_b}, 2'b00);
    rd(`CSSB_ADDR_CTRL, 32'h0);
    repeat (4) @(posedge ref_clk);
    wr(`CSSB_ADDR_CTRL, 32'h400);
    #1 chk({general_output_a, general_output_b}, 2'b10);
    wr(`CSSB_ADDR_CTRL, 32'h800);
    #1 chk({general_output_a, general_output_b}, 2'b01);
    wr(8'h3c, 32'hc00);
    rd(8'h3c, 32'h0);
    rd(`CSSB_ADDR_CTRL, 32'h800);
    pins(1'b1, 1'b1);
    chk({general_output_a, general_output_b, secondary_frame_sync}, 3'b001);
    rd(`CSSB_ADDR_STAT, 32'h100);
    frame(16'ha5c3, 16'h3c5a);
    chk(rx_word, 16'ha5c3);
    chk(dac_got, 16'h3c5a);
    chk(lo_last inside {[9:10]}, 1'b1);
    chk({sec_low, dac_sec}, 2'b00);
    rd(`CSSB_ADDR_RXWORD, 32'h3c5a);
    pins(1'b1, 1'b0);
    frame(16'h81e7, 16'h7e18);
    chk(rx_word, 16'h81e7);
    chk(dac_got, 16'h7e18);
    chk(lo_last inside {[84:89]}, 1'b1);
    rd(`CSSB_ADDR_STAT, 32'h120);
    pins(1'b0, 1'b1);
    secondary_data_in <= 1'b1;
    n = rx_cnt;
    wr(`CSSB_ADDR_CTRL, 32'h1);
    wait_rx(n + 1);
    chk(rx_word, 16'hffff);
    chk({sec_low, eod_low, dac_sec}, 3'b101);
    rd(`CSSB_ADDR_STAT, 32'h150);
    rd(`CSSB_ADDR_CTRL, 32'h0);
    pins(1'b1, 1'b1);
    n = rx_cnt;
    k = 0;
    adc_data <= 16'h1000;
    adc_valid <= 1'b1;
    do begin
      #1 r = adc_ready;
      @(posedge ref_clk);
      if (r) k++;
      adc_data <= 16'h1000 + k[15:0];
    end while (r && k < 40);
    adc_valid <= 1'b0;
    chk(k >= 32 && k < 40, 1'b1);
    wait_rx(n + k);
    chk(rx_word, 16'h1000 + k[15:0] - 16'h1);
    stop_test;
  end
endmodule
